// >>> inc/sram_ctl_pkg.sv
/*
 * Shared constants and types for the burst SRAM cycle control.
 * Assumes one 40 MHz clock and that every pin except the output enable and the reset is synchronous to it.
 */
`default_nettype none
package sram_ctl_pkg;
    // Geometry of the array behind the control logic.
    localparam int ADDR_W = 18;
    localparam int DATA_W = 32;
    localparam int LANES = 4;
    localparam int LANE_W = 8;

    // Clock period in nanoseconds.
    localparam int CLK_PERIOD_NS = 25;

    // Sleep entry and recovery times, in clock periods.
    localparam int SLEEP_ENTRY_TCYC = 2;
    localparam int SLEEP_EXIT_TCYC = 2;
    localparam logic [1:0] SLEEP_ENTRY_COUNT = 2'(SLEEP_ENTRY_TCYC);
    localparam logic [1:0] SLEEP_EXIT_COUNT = 2'(SLEEP_EXIT_TCYC);

    // Reset values.
    localparam logic [ADDR_W-3:0] ADDR_HI_RESET = 16'h0000;
    localparam logic [1:0] BURST_RESET = 2'h0;
    localparam logic [LANES-1:0] LANES_NONE = 4'h0;
    localparam logic [LANES-1:0] LANES_ALL = 4'hF;
    localparam logic [DATA_W-1:0] DATA_RESET = 32'h0000_0000;

    // Cycle currently in progress.
    typedef enum logic [1:0] {
        CYC_IDLE = 2'b00,
        CYC_READ = 2'b01,
        CYC_WRITE = 2'b10,
        CYC_SLEEP = 2'b11
    } cycle_e;
endpackage
`default_nettype wire

// >>> rtl/burst_sequencer.sv
/*
 * Two-bit wraparound burst address generator, interleaved or linear.
 * Assumes the caller gives load priority over advance.
 */
`timescale 1ns/1ps
`default_nettype none
module burst_sequencer (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset_n,
    // Control.
    input wire logic load,
    input wire logic [1:0] seed,
    input wire logic advance,
    input wire logic interleaved,
    // Low address bits of the current beat.
    output logic [1:0] low_addr
);
    import sram_ctl_pkg::*;

    typedef struct packed {
        logic [1:0] start;
        logic [1:0] count;
    } seq_s;

    seq_s q, d;

    // A load restarts the count; an advance on the loading edge is ignored.
    always_comb begin
        d = q;
        if (load) begin
            d.start = seed;
            d.count = BURST_RESET;
        end else if (advance) begin
            d.count = q.count + 2'b01;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            q <= '{start: BURST_RESET, count: BURST_RESET};
        end else begin
            q <= d;
        end
    end

    // The order pin acts at once, so a change mid-burst reorders what remains.
    assign low_addr = interleaved ? (q.start ^ q.count) : (q.start + q.count);
endmodule
`default_nettype wire

// >>> rtl/sram_cycle_control.sv
/*
 * Cycle control of a pipelined synchronous burst SRAM: strobe decode,
 * write-lane decode, burst addressing, sleep sequencing and data drivers.
 * Assumes the array is outside, takes array_addr and array_write_lanes in
 * the cycle after an edge, and returns array_rdata within that cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module sram_cycle_control (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset_n,
    // Address and chip enables.
    input wire logic [sram_ctl_pkg::ADDR_W-1:0] addr,
    input wire logic primary_chip_enable_n,
    input wire logic high_chip_enable,
    input wire logic secondary_chip_enable_n,
    // Strobes and burst control.
    input wire logic processor_addr_strobe_n,
    input wire logic controller_addr_strobe_n,
    input wire logic burst_advance_n,
    input wire logic burst_order_select,
    // Write controls.
    input wire logic global_write_n,
    input wire logic byte_write_enable_n,
    input wire logic lane_a_write_select_n,
    input wire logic lane_b_write_select_n,
    input wire logic lane_c_write_select_n,
    input wire logic lane_d_write_select_n,
    // Output enable, which acts asynchronously, and sleep request, sampled at the clock.
    input wire logic output_enable_n,
    input wire logic sleep_request,
    // Common data pins.
    input wire logic [sram_ctl_pkg::DATA_W-1:0] data_in,
    output logic [sram_ctl_pkg::DATA_W-1:0] data_out,
    output logic [sram_ctl_pkg::DATA_W-1:0] data_oe,
    // Array side.
    output logic [sram_ctl_pkg::ADDR_W-1:0] array_addr,
    output logic [sram_ctl_pkg::LANES-1:0] array_write_lanes,
    output logic [sram_ctl_pkg::DATA_W-1:0] array_wdata,
    input wire logic [sram_ctl_pkg::DATA_W-1:0] array_rdata,
    // Status.
    output logic sleep_active
);
    import sram_ctl_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        cycle_e cyc;
        logic [ADDR_W-3:0] addr_hi;
        logic [LANES-1:0] lanes;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] rdata;
        logic [1:0] sleep_cnt;
    } ctl_s;

    ctl_s q, d;
    logic seq_load;
    logic seq_adv;
    logic decode_en;
    logic selected;
    logic processor_addr_strobe_n_go;
    logic [LANES-1:0] wr_lanes;
    logic [1:0] low_addr;

    // Lane A is bit 0; global write selects every lane.
    function automatic logic [LANES-1:0] lane_decode(input logic gw_n, input logic bwe_n,
                                                     input logic [LANES-1:0] sel_n);
        if (!gw_n) begin
            return LANES_ALL;
        end else if (!bwe_n) begin
            return ~sel_n;
        end
        return LANES_NONE;
    endfunction

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    // The processor strobe is honoured only with the primary enable low.
    assign selected = !primary_chip_enable_n && high_chip_enable && !secondary_chip_enable_n;
    assign processor_addr_strobe_n_go = !processor_addr_strobe_n && !primary_chip_enable_n;
    assign wr_lanes = lane_decode(global_write_n, byte_write_enable_n,
        {lane_d_write_select_n, lane_c_write_select_n,
         lane_b_write_select_n, lane_a_write_select_n});

    // Next-state logic; sleep sequencing has priority over any access.
    always_comb begin
        d = q;
        seq_load = 1'b0;
        seq_adv = 1'b0;
        decode_en = 1'b0;
        d.lanes = LANES_NONE;
        d.wdata = data_in;
        d.rdata = array_rdata;
        if (q.cyc == CYC_SLEEP) begin
            // Strobes are ignored until recovery completes.
            if (sleep_request) begin
                d.sleep_cnt = 2'b00;
            end else if (q.sleep_cnt == SLEEP_EXIT_COUNT - 2'b01) begin
                d.cyc = CYC_IDLE;
                d.sleep_cnt = 2'b00;
            end else begin
                d.sleep_cnt = q.sleep_cnt + 2'b01;
            end
        end else if (sleep_request && q.sleep_cnt == SLEEP_ENTRY_COUNT - 2'b01) begin
            // A pending access is abandoned on entry.
            d.cyc = CYC_SLEEP;
            d.sleep_cnt = 2'b00;
        end else begin
            decode_en = 1'b1;
            d.sleep_cnt = sleep_request ? q.sleep_cnt + 2'b01 : 2'b00;
            if (processor_addr_strobe_n_go) begin
                // Write controls are ignored on this edge.
                if (selected) begin
                    d.cyc = CYC_READ;
                    seq_load = 1'b1;
                    d.addr_hi = addr[ADDR_W-1:2];
                end else begin
                    d.cyc = CYC_IDLE;
                end
            end else if (!controller_addr_strobe_n) begin
                if (selected) begin
                    d.cyc = (|wr_lanes) ? CYC_WRITE : CYC_READ;
                    d.lanes = wr_lanes;
                    seq_load = 1'b1;
                    d.addr_hi = addr[ADDR_W-1:2];
                end else begin
                    d.cyc = CYC_IDLE;
                end
            end else if (q.cyc != CYC_IDLE) begin
                // Continue on advance, otherwise hold the address.
                seq_adv = !burst_advance_n;
                d.cyc = (|wr_lanes) ? CYC_WRITE : CYC_READ;
                d.lanes = wr_lanes;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            q <= '{cyc: CYC_IDLE, addr_hi: ADDR_HI_RESET, lanes: LANES_NONE,
                   wdata: DATA_RESET, rdata: DATA_RESET, sleep_cnt: 2'b00};
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // Burst addressing
    // ----------------------------------------------------------------
    burst_sequencer u_seq (
        .clk(clk),
        .reset_n(reset_n),
        .load(seq_load),
        .seed(addr[1:0]),
        .advance(seq_adv),
        .interleaved(burst_order_select),
        .low_addr(low_addr)
    );

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // The output enable is not registered, so it acts within the cycle; a
    // write cycle masks it so a late enable cannot fight the master's data.
    assign data_oe = {DATA_W{(q.cyc == CYC_READ) && !output_enable_n}};
    assign data_out = q.rdata;
    assign array_addr = {q.addr_hi, low_addr};
    assign array_write_lanes = q.lanes;
    assign array_wdata = q.wdata;
    assign sleep_active = (q.cyc == CYC_SLEEP);

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // Controller-strobe write lanes land on the array one cycle later.
    AST_GLOBAL_WRITE: assert property (
        decode_en && processor_addr_strobe_n && !controller_addr_strobe_n && selected
        && !global_write_n |=> array_write_lanes == LANES_ALL)
        else $error("Global write did not select all lanes.");
    AST_BYTE_LANES: assert property (
        decode_en && q.cyc != CYC_IDLE && processor_addr_strobe_n && global_write_n
        && !byte_write_enable_n && (controller_addr_strobe_n || selected)
        |=> array_write_lanes == ~$past({lane_d_write_select_n,
        lane_c_write_select_n, lane_b_write_select_n, lane_a_write_select_n}))
        else $error("Byte write lanes do not match the selects.");
    AST_NO_WRITE: assert property (
        global_write_n && byte_write_enable_n |=> array_write_lanes == LANES_NONE)
        else $error("Write lanes set with no write control active.");
    AST_PROCESSOR_ADDR_STROBE_N_READ: assert property (
        decode_en && processor_addr_strobe_n_go && selected |=> q.cyc == CYC_READ && array_write_lanes == 0)
        else $error("Processor strobe did not begin a read.");
    AST_WRITE_IN_WRITE: assert property (
        |array_write_lanes |-> q.cyc == CYC_WRITE)
        else $error("Array written outside a write cycle.");
    AST_OE_COMB: assert property (
        q.cyc == CYC_READ && $stable(q.cyc) && $fell(output_enable_n) |-> &data_oe)
        else $error("Output enable did not act in the same cycle.");
    AST_WRITE_FLOAT: assert property (
        q.cyc == CYC_WRITE |-> data_oe == '0)
        else $error("Data driven during a write cycle.");
    AST_READ_FLOAT: assert property (
        q.cyc == CYC_READ && output_enable_n |-> data_oe == '0)
        else $error("Read drove data with output enable high.");
    AST_READ_DRIVE: assert property (
        q.cyc == CYC_READ && !output_enable_n |-> &data_oe)
        else $error("Read did not drive all data pins.");
    AST_ADVANCE: assert property (
        decode_en && q.cyc != CYC_IDLE && processor_addr_strobe_n && controller_addr_strobe_n
        && !burst_advance_n && !burst_order_select ##1 !burst_order_select
        |-> array_addr[1:0] == $past(array_addr[1:0]) + 2'b01)
        else $error("Linear burst did not step by one.");
    AST_SUSPEND: assert property (
        decode_en && q.cyc != CYC_IDLE && processor_addr_strobe_n && controller_addr_strobe_n
        && burst_advance_n && $stable(burst_order_select) ##1 $stable(burst_order_select)
        |-> $stable(array_addr))
        else $error("Suspended burst moved its address.");
    AST_DESELECT: assert property (
        decode_en && processor_addr_strobe_n && !controller_addr_strobe_n && !selected
        |=> q.cyc == CYC_IDLE && data_oe == '0)
        else $error("Unselected strobe did not deselect.");
    AST_SLEEP_IN: assert property (
        $rose(sleep_request) && q.cyc != CYC_SLEEP ##1 sleep_request |=> sleep_active)
        else $error("Sleep not entered after two cycles.");
    AST_SLEEP_OUT: assert property (
        $fell(sleep_request) && sleep_active ##1 !sleep_request |=> q.cyc == CYC_IDLE)
        else $error("Sleep not left after two cycles.");

    COV_READ: cover property (processor_addr_strobe_n_go && selected ##1 !output_enable_n);
    COV_WRITE: cover property (!controller_addr_strobe_n && selected && !global_write_n);
    COV_BURST: cover property (q.cyc == CYC_READ && !burst_advance_n [*3]);
    COV_SLEEP: cover property (sleep_active ##1 !sleep_active);
endmodule
`default_nettype wire

// >>> testbench/sram_array_model.sv
/*
 * Behavioural model of the storage array beside the cycle control.
 * Assumes lanes and address are valid in the cycle after an edge.
 */
`timescale 1ns/1ps
`default_nettype none
module sram_array_model (
    // Clock.
    input wire logic clk,
    // Array side of the cycle control.
    input wire logic [17:0] array_addr,
    input wire logic [3:0] array_write_lanes,
    input wire logic [31:0] array_wdata,
    output logic [31:0] array_rdata
);
    // ----------------------------------------
    // Storage
    // ----------------------------------------
    // Only sixteen words are kept; the bench never needs more.
    logic [31:0] mem [0:15];

    // Preload a pattern the bench can predict.
    initial begin
        for (int i = 0; i < 16; i++) begin
            mem[i] = 32'h1111_1111 * i;
        end
    end

    // Read answers within the same cycle, as the control expects.
    assign array_rdata = mem[array_addr[3:0]];

    // Each set lane writes its byte at the edge closing the cycle.
    always @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            if (array_write_lanes[i]) begin
                mem[array_addr[3:0]][8*i +: 8] <= array_wdata[8*i +: 8];
            end
        end
    end
endmodule
`default_nettype wire

// >>> testbench/pipelined_sync_sram_cycle_control_bench.sv
/*
 * Self-checking bench for the burst SRAM cycle control.
 * Assumes the array model above and a 40 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module pipelined_sync_sram_cycle_control_bench;
    import sram_ctl_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic clk = 0, reset_n = 0, ce1_n = 0, ce2 = 1, ce3_n = 0, psn = 1, csn = 1, adv_n = 1;
    logic order = 1, gw_n = 1, bwe_n = 1, oe_n = 1, sleep_request = 0;
    logic [3:0] sel_n = 4'hF;
    logic [17:0] addr = 18'h0_0000;
    logic [31:0] data_in = 32'h0000_0000, data_out, data_oe, wdata, rdata;
    logic [17:0] array_addr;
    logic [3:0] lanes, el;
    logic sleep_active;
    logic [31:0] exp_mem [0:15];
    logic [31:0] d, seed = 32'h0bd2_1aad;
    int errors = 0, checks_done = 0, prev, nx;

    always #12.5 clk = ~clk;

    sram_cycle_control dut_u (.clk(clk), .reset_n(reset_n), .addr(addr),
        .primary_chip_enable_n(ce1_n), .high_chip_enable(ce2), .secondary_chip_enable_n(ce3_n),
        .processor_addr_strobe_n(psn), .controller_addr_strobe_n(csn),
        .burst_advance_n(adv_n), .burst_order_select(order), .global_write_n(gw_n),
        .byte_write_enable_n(bwe_n), .lane_a_write_select_n(sel_n[0]),
        .lane_b_write_select_n(sel_n[1]), .lane_c_write_select_n(sel_n[2]),
        .lane_d_write_select_n(sel_n[3]), .output_enable_n(oe_n),
        .sleep_request(sleep_request), .data_in(data_in), .data_out(data_out),
        .data_oe(data_oe), .array_addr(array_addr), .array_write_lanes(lanes),
        .array_wdata(wdata), .array_rdata(rdata), .sleep_active(sleep_active));
    sram_array_model array_u (.clk(clk), .array_addr(array_addr),
        .array_write_lanes(lanes), .array_wdata(wdata), .array_rdata(rdata));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    // Inputs change at the falling edge, so results are read there too.
    task automatic step();
        @(posedge clk);
        @(negedge clk);
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Hang guard: the tests need well under a thousand cycles.
    initial begin
        repeat (3000) @(posedge clk);
        errors++;
        close_out();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        for (int i = 0; i < 16; i++) exp_mem[i] = 32'h1111_1111 * i;
        repeat (5) @(negedge clk);
        reset_n = 1;
        check(data_oe, 32'h0000_0000);
        check(32'({lanes, sleep_active}), 32'h0000_0000);
        // Controller-strobe writes over every lane pattern, then a global write.
        for (int k = 0; k < 17; k++) begin
            d = $random(seed);
            addr = 18'(d[31:14]);
            data_in = $random(seed);
            {csn, oe_n, bwe_n} = 3'b010;
            gw_n = (k != 16);
            sel_n = 4'(k);
            el = (k == 16) ? 4'hF : ~4'(k);
            step();
            check(32'(lanes), 32'(el));
            check(32'(array_addr), 32'(addr));
            if (el != 4'h0) check(wdata, data_in);
            for (int i = 0; i < 4; i++) begin
                if (el[i]) exp_mem[addr[3:0]][8*i +: 8] = data_in[8*i +: 8];
            end
            oe_n = 0;
            #1 check(data_oe, (el == 4'h0) ? 32'hFFFF_FFFF : 32'h0000_0000);
        end
        {csn, gw_n, bwe_n, sel_n} = 7'h7F;
        $display("test lane writes done");
        // Processor-strobe read bursts in both orders, with global write low on the strobe.
        for (int m = 0; m < 8; m++) begin
            order = m[2];
            d = $random(seed);
            addr = {d[17:4], 4'h0} | 18'(m % 4);
            {psn, gw_n, oe_n} = 3'b000;
            step();
            check(32'(lanes), 32'h0000_0000);
            check(data_oe, 32'hFFFF_FFFF);
            oe_n = 1;
            #1 check(data_oe, 32'h0000_0000);
            {psn, gw_n, oe_n, adv_n} = 4'b1100;
            prev = m % 4;
            for (int n = 1; n < 5; n++) begin
                adv_n = (n == 4);
                // Processor strobe with the primary enable high must not break the burst.
                {psn, ce1_n} = (n == 2) ? 2'b01 : 2'b10;
                step();
                check(data_out, exp_mem[prev]);
                nx = order ? ((m % 4) ^ n) : ((m % 4 + n) % 4);
                if (n == 4) nx = prev;
                check(32'(array_addr[1:0]), 32'(nx));
                prev = nx;
            end
        end
        $display("test read bursts done");
        // Processor start then a global write on the next clock.
        {psn, oe_n, adv_n} = 3'b011;
        addr = 18'h0_0005;
        step();
        {psn, gw_n} = 2'b10;
        data_in = $random(seed);
        oe_n = 0;
        step();
        check(32'(lanes), 32'h0000_000F);
        check(data_oe, 32'h0000_0000);
        check(32'(array_addr), 32'h0000_0005);
        check(wdata, data_in);
        exp_mem[5] = data_in;
        // Continue the write; interleaved order steps from 1 to 0.
        adv_n = 0;
        data_in = $random(seed);
        step();
        check(32'(lanes), 32'h0000_000F);
        check(32'(array_addr), 32'h0000_0004);
        check(wdata, data_in);
        check(data_oe, 32'h0000_0000);
        exp_mem[4] = data_in;
        {gw_n, adv_n} = 2'b11;
        // Controller strobe with the high enable low deselects.
        {csn, ce2} = 2'b00;
        step();
        check(data_oe, 32'h0000_0000);
        check(32'(lanes), 32'h0000_0000);
        // A processor-strobe read, then one with the secondary enable high.
        {csn, ce2, psn} = 3'b110;
        step();
        check(data_oe, 32'hFFFF_FFFF);
        ce3_n = 1;
        step();
        check(data_oe, 32'h0000_0000);
        check(data_out, exp_mem[5]);
        {psn, ce3_n, ce1_n} = 3'b101;
        $display("test write and deselect done");
        // Sleep takes two edges in and two edges out.
        sleep_request = 1;
        step();
        check(32'(sleep_active), 32'h0000_0000);
        step();
        check(32'(sleep_active), 32'h0000_0001);
        check(data_oe, 32'h0000_0000);
        sleep_request = 0;
        step();
        check(32'(sleep_active), 32'h0000_0001);
        step();
        check(32'(sleep_active), 32'h0000_0000);
        $display("test sleep done");
        close_out();
    end
endmodule
`default_nettype wire
